// file: hw/serial_port_buffer_status_flags.sv
// Purpose: status flags for serial port transmit and receive buffering
// Assumes: classic Wishbone slave, one clock, synchronous reset
// Notes: ack one cycle after request, unmapped reads give zero
`timescale 1ns/1ns
`default_nettype none

// How it works
// RULE_01 - Bit 1 reads transmit holding buffer full
// RULE_02 - Standard: data window write sets flag
// RULE_03 - Standard: move to shift register clears
// RULE_04 - Enhanced: write filling last location sets
// RULE_05 - Enhanced: any free location clears flag
// RULE_06 - Bit 0 reads receive holding buffer full
// RULE_07 - Standard: shift register transfer sets flag
// RULE_08 - Standard: data window read clears flag
// RULE_09 - Enhanced: transfer filling last location sets
// RULE_10 - Enhanced: any available location clears flag
// RULE_11 - Software writes never change both flags
module serial_port_buffer_status_flags
  import sp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic busy_o,
  output logic irq_o
);
  // ==========================================
  // Pin input synchroniser
  logic sdi_meta_q;
  logic sdi_sync_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sdi_meta_q <= 1'b0;
      sdi_sync_q <= 1'b0;
    end else if (ce_i) begin
      sdi_meta_q <= sdi_i;
      sdi_sync_q <= sdi_meta_q;
    end
  end

  // ==========================================
  // Bus decode
  logic req;
  logic wr_data;
  logic rd_data;
  logic wr_stat;
  logic wr_irq_st;
  logic wr_irq_mask;

  function automatic logic hit(input logic [3:0] adr, input logic [3:0] off);
    hit = adr == off;
  endfunction : hit

  // One-cycle answer; the held request is taken only while ack is low
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_data = req && wb_we_i && hit(wb_adr_i, REG_DATA) && (&wb_sel_i[1:0]);
  assign rd_data = req && !wb_we_i && hit(wb_adr_i, REG_DATA);
  assign wr_stat = req && wb_we_i && hit(wb_adr_i, REG_STAT);
  assign wr_irq_st = req && wb_we_i && hit(wb_adr_i, REG_IRQ_STATUS);
  assign wr_irq_mask = req && wb_we_i && hit(wb_adr_i, REG_IRQ_MASK);

  // ==========================================
  // Control register
  logic [15:0] ctrl_q;
  logic enh;
  logic en;

  assign enh = ctrl_q[ENH_BIT];
  assign en = ctrl_q[ENABLE_BIT];

  // Flag positions are outside the write mask, so writes leave them alone
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= STAT_RESET;
    end else if (ce_i && wr_stat && wb_sel_i[0] && wb_sel_i[1]) begin
      ctrl_q <= wb_dat_i[15:0] & STAT_WMASK; // RULE_11
    end
  end

  // ==========================================
  // Transmit and receive buffers
  logic tx_full;
  logic tx_empty;
  logic [DATA_W-1:0] tx_data;
  logic rx_full;
  logic rx_empty;
  logic [DATA_W-1:0] rx_data;
  logic sh_busy;
  logic sh_done;
  logic [DATA_W-1:0] sh_data;
  logic sh_sdo;
  logic tx_move;

  // Holding buffer drains into the shifter when enabled and the shifter idles
  assign tx_move = en && !tx_empty && !sh_busy;

  sp_buffer u_tx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .enh_i(enh),
    .push_i(wr_data), // RULE_02
    .data_i(wb_dat_i[DATA_W-1:0]),
    .pop_i(tx_move), // RULE_03
    .data_o(tx_data),
    .full_o(tx_full), // RULE_04
    .empty_o(tx_empty)
  );

  sp_buffer u_rx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .enh_i(enh),
    .push_i(sh_done), // RULE_07
    .data_i(sh_data),
    .pop_i(rd_data), // RULE_08
    .data_o(rx_data),
    .full_o(rx_full), // RULE_09
    .empty_o(rx_empty)
  );

  sp_shifter u_sh (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .en_i(en),
    .load_i(tx_move),
    .data_i(tx_data),
    .sdi_i(sdi_sync_q),
    .sdo_o(sh_sdo),
    .busy_o(sh_busy),
    .done_o(sh_done),
    .data_o(sh_data)
  );

  // ==========================================
  // Registered flags and pins
  logic tbf_q;
  logic rbf_q;
  logic sdo_q;
  logic busy_q;

  // Flags follow occupancy: a freed location clears them one clock later in enhanced mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tbf_q <= 1'b0;
      rbf_q <= 1'b0;
    end else if (ce_i) begin
      tbf_q <= tx_full; // RULE_01 RULE_05
      rbf_q <= rx_full; // RULE_06 RULE_10
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sdo_q <= 1'b0;
      busy_q <= 1'b0;
    end else if (ce_i) begin
      sdo_q <= sh_sdo;
      busy_q <= sh_busy;
    end
  end

  assign sdo_o = sdo_q;
  assign busy_o = busy_q;

  // ==========================================
  // Interrupts
  logic [IRQ_W-1:0] irq_st_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_ev;
  logic irq_q;

  assign irq_ev[IRQ_TX_SPACE] = tx_move;
  assign irq_ev[IRQ_RX_DATA] = sh_done;
  assign irq_ev[IRQ_RX_OVF] = sh_done && rx_full;

  // New event wins over a same-cycle clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_st_q <= '0;
    end else if (ce_i) begin
      irq_st_q <= (irq_st_q & ~(wr_irq_st ? wb_dat_i[IRQ_W-1:0] : '0)) | irq_ev;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_q <= '0;
    end else if (ce_i && wr_irq_mask) begin
      irq_mask_q <= wb_dat_i[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else if (ce_i) begin
      irq_q <= |(irq_st_q & irq_mask_q);
    end
  end

  assign irq_o = irq_q;

  // ==========================================
  // Read mux and ack
  logic [31:0] rdata_d;
  logic [15:0] stat_view;

  always_comb begin
    stat_view = ctrl_q;
    stat_view[TBF_BIT] = tbf_q;
    stat_view[RBF_BIT] = rbf_q;
    stat_view[SHIFT_EMPTY_BIT] = !sh_busy;
    case (wb_adr_i)
      REG_DATA: rdata_d = {16'h0000, rx_data};
      REG_STAT: rdata_d = {16'h0000, stat_view};
      REG_IRQ_STATUS: rdata_d = {29'h0000000, irq_st_q};
      REG_IRQ_MASK: rdata_d = {29'h0000000, irq_mask_q};
      default: rdata_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (ce_i) begin
      wb_ack_o <= req;
      wb_dat_o <= req && !wb_we_i ? rdata_d : 32'h00000000;
    end
  end
endmodule : serial_port_buffer_status_flags
`default_nettype wire

// file: include/sp_pkg.sv
// Purpose: constants for the serial port buffer status flag block
// Assumes: classic Wishbone, 32-bit data, word-aligned byte offsets
// Notes: widths fixed
package sp_pkg;
  // ==========================================
  // Register map
  localparam logic [3:0] REG_DATA = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_IRQ_STATUS = 4'h8;
  localparam logic [3:0] REG_IRQ_MASK = 4'hC;
  // ==========================================
  // Status fields
  localparam int RBF_BIT = 0;
  localparam int TBF_BIT = 1;
  localparam int ENH_BIT = 2;
  localparam int SHIFT_EMPTY_BIT = 3;
  localparam int ENABLE_BIT = 15;
  localparam logic [15:0] STAT_RESET = 16'h0000;
  localparam logic [15:0] STAT_WMASK = 16'h8004;
  // Interrupt fields
  localparam int IRQ_TX_SPACE = 0;
  localparam int IRQ_RX_DATA = 1;
  localparam int IRQ_RX_OVF = 2;
  localparam int IRQ_W = 3;
  // ==========================================
  // Sizes
  localparam int DATA_W = 16;
  localparam int DEPTH = 4;
  localparam int PTR_W = 2;
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] STD_DEPTH = 3'h1;
  localparam logic [CNT_W-1:0] ENH_DEPTH = 3'h4;
  localparam logic [4:0] SHIFT_BITS = 5'h10;
  localparam logic [4:0] SHIFT_LAST = SHIFT_BITS - 5'h1;
endpackage : sp_pkg

// file: hw/sp_buffer.sv
// Purpose: holding buffer, one location in standard mode, four in enhanced
// Assumes: push and pop from the same clock
// Notes: full follows the active depth
`timescale 1ns/1ns
`default_nettype none
module sp_buffer
  import sp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic enh_i,
  input wire logic push_i,
  input wire logic [DATA_W-1:0] data_i,
  input wire logic pop_i,
  output logic [DATA_W-1:0] data_o,
  output logic full_o,
  output logic empty_o
);
  // ==========================================
  // Storage
  logic [DATA_W-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_q;
  logic [PTR_W-1:0] rd_q;
  logic [CNT_W-1:0] cnt_q;
  logic do_push;
  logic do_pop;

  // Limit drops to one location in standard mode
  assign full_o = cnt_q >= (enh_i ? ENH_DEPTH : STD_DEPTH);
  assign empty_o = cnt_q == '0;
  assign do_push = push_i && !full_o;
  assign do_pop = pop_i && !empty_o;
  assign data_o = mem_q[rd_q];

  always_ff @(posedge clk_i) begin
    if (ce_i && do_push) begin
      mem_q[wr_q] <= data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (ce_i) begin
      if (do_push) begin
        wr_q <= wr_q + 2'h1;
      end
      if (do_pop) begin
        rd_q <= rd_q + 2'h1;
      end
      cnt_q <= cnt_q + CNT_W'(do_push) - CNT_W'(do_pop);
    end
  end
endmodule : sp_buffer
`default_nettype wire

// file: hw/sp_shifter.sv
// Purpose: shift engine moving one word per frame
// Assumes: one bit per enabled clock, loopback-free full duplex
// Notes: link timing is a simple stand-in
`timescale 1ns/1ns
`default_nettype none
module sp_shifter
  import sp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic en_i,
  input wire logic load_i,
  input wire logic [DATA_W-1:0] data_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic busy_o,
  output logic done_o,
  output logic [DATA_W-1:0] data_o
);
  // ==========================================
  // Shift register
  logic [DATA_W-1:0] sr_q;
  logic [4:0] cnt_q;

  assign sdo_o = sr_q[DATA_W-1];
  assign data_o = sr_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sr_q <= '0;
      cnt_q <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (!en_i) begin
        busy_o <= 1'b0;
        cnt_q <= '0;
      end else if (load_i && !busy_o) begin
        sr_q <= data_i;
        cnt_q <= '0;
        busy_o <= 1'b1;
      end else if (busy_o) begin
        sr_q <= {sr_q[DATA_W-2:0], sdi_i};
        cnt_q <= cnt_q + 5'h1;
        if (cnt_q == SHIFT_LAST) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end
endmodule : sp_shifter
`default_nettype wire

// file: bench/sp_flags_chk.sv
// Purpose: port checks for the status flag block
// Assumes: ce_i held high by the bench
// Notes: flags are only visible through bus reads
`timescale 1ns/1ns
`default_nettype none
module sp_flags_chk
  import sp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic busy_o,
  input wire logic irq_o
);
  // ==========
  // Checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  endsequence
  sequence s_wr_done;
    wb_ack_o && wb_we_i;
  endsequence
  a_ack_next: assert property (s_req |=> wb_ack_o) else $error("ack missing");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack unasked");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data not quiet");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0) else $error("upper data set");
  a_shift_span: assert property ($rose(busy_o) |-> busy_o [*8]) else $error("frame short");
  a_irq_fall: assert property ($fell(irq_o) |-> $past(wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i, 2))
    else $error("irq fell alone");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !busy_o && !irq_o)
    else $error("reset not quiet");
  c_write: cover property (s_wr_done);
endmodule : sp_flags_chk
bind serial_port_buffer_status_flags sp_flags_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .busy_o(busy_o), .irq_o(irq_o));
`default_nettype wire

// file: bench/sp_link_peer.sv
// Purpose: far end of the serial link
// Assumes: sends a rotating pattern while a frame runs
// Notes: toggles between frames so no stale level passes
`timescale 1ns/1ns
`default_nettype none
module sp_link_peer (
  input wire logic clk_i,
  input wire logic busy_i,
  output logic sdi_o
);
  logic [15:0] pat_q = 16'hA5C3;
  initial sdi_o = 1'b0;
  always @(posedge clk_i) begin
    if (busy_i) begin
      sdi_o <= pat_q[15];
      pat_q <= {pat_q[14:0], pat_q[15]};
    end else begin
      sdi_o <= ~sdi_o;
    end
  end
endmodule : sp_link_peer
`default_nettype wire

// file: bench/serial_port_buffer_status_flags_tb.sv
// Purpose: self-checking bench for the status flag block
// Assumes: reads checked against masked expectations
// Notes: received data values not compared, link alignment is loose
`timescale 1ns/1ns
`default_nettype none
module serial_port_buffer_status_flags_tb;
  import sp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, e;
  logic [15:0] w, w0;
  logic sdi, sdo, busy, ack, irq;
  logic [31:0] exp_q[$];
  int n_fail = 0;
  int compares = 0;
  int cyc_n = 0;
  always #2 clk_i = ~clk_i;
  serial_port_buffer_status_flags i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .sdi_i(sdi), .sdo_o(sdo), .busy_o(busy), .irq_o(irq));
  sp_link_peer i_peer (.clk_i(clk_i), .busy_i(busy), .sdi_o(sdi));
  // ==========
  // Tasks
  task automatic chk(input string what, input logic [31:0] x, input logic [31:0] s);
    compares++;
    if (s !== x) begin
      n_fail++;
      $display("wrong value %s exp %h got %h", what, x, s);
    end
  endtask : chk
  // Mask in upper half, expected value in lower; mask zero means no compare
  task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d, input logic [15:0] m);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0, d};
    exp_q.push_back({m, d});
    do @(posedge clk_i); while (ack !== 1'b1);
    cyc <= 1'b0;
  endtask : acc
  task automatic idle;
    int n;
    n = 0;
    while (n < 8) begin
      @(posedge clk_i);
      n = (busy === 1'b0) ? n + 1 : 0;
    end
  endtask : idle
  task automatic report_and_stop;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  // ==========
  // Monitor and timeout
  always @(posedge clk_i) begin
    if (ack === 1'b1) begin
      e = exp_q.pop_front();
      if (e[31:16] != 16'h0)
        chk("read", {16'h0, e[15:0] & e[31:16]}, {rdat[31:16], rdat[15:0] & e[31:16]});
    end
    cyc_n++;
    if (cyc_n == 4000) begin
      n_fail++;
      report_and_stop();
    end
  end
  // ==========
  // Scenarios
  initial begin
    void'($urandom(32'h227C7008));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    acc(0, REG_STAT, 16'h0000, 16'h8007);
    acc(0, 4'h2, 16'h0000, 16'hFFFF);
    acc(1, 4'h6, 16'hFFFF, 16'h0);
    acc(1, REG_DATA, 16'($urandom), 16'h0);
    acc(0, REG_STAT, 16'h0002, 16'h0003);
    acc(1, REG_STAT, 16'h8000, 16'h0);
    idle();
    acc(0, REG_STAT, 16'h0001, 16'h0003);
    acc(1, REG_STAT, 16'h8002, 16'h0);
    acc(0, REG_STAT, 16'h8001, 16'h8003);
    chk("irq", 32'h0, {31'h0, irq});
    acc(0, REG_IRQ_STATUS, 16'h0003, 16'h0007);
    acc(1, REG_IRQ_MASK, 16'h0002, 16'h0);
    repeat (2) @(posedge clk_i);
    chk("irq", 32'h1, {31'h0, irq});
    acc(1, REG_IRQ_STATUS, 16'h0007, 16'h0);
    repeat (2) @(posedge clk_i);
    chk("irq", 32'h0, {31'h0, irq});
    acc(0, REG_DATA, 16'h0, 16'h0);
    acc(0, REG_STAT, 16'h0000, 16'h0003);
    // Disabled while filling, so no word leaves early
    acc(1, REG_STAT, 16'h0004, 16'h0);
    for (int i = 0; i < 4; i++) begin
      acc(0, REG_STAT, 16'h0004, 16'h0006);
      w = 16'($urandom);
      if (i == 0) w0 = w;
      acc(1, REG_DATA, w, 16'h0);
    end
    acc(0, REG_STAT, 16'h0006, 16'h0006);
    acc(1, REG_STAT, 16'h8004, 16'h0);
    do @(posedge clk_i); while (busy !== 1'b1);
    chk("sdo", {31'h0, w0[15]}, {31'h0, sdo});
    acc(0, REG_STAT, 16'h0000, 16'h0002);
    idle();
    acc(0, REG_STAT, 16'h0001, 16'h0003);
    acc(0, REG_DATA, 16'h0, 16'h0);
    acc(0, REG_STAT, 16'h0000, 16'h0001);
    repeat (2) @(posedge clk_i);
    report_and_stop();
  end
endmodule : serial_port_buffer_status_flags_tb
`default_nettype wire
